// File: pkg/plii_pkg.sv
// Constants shared by the interrupt aggregation logic
//
// Contract
// - Enabled bus-side status bit raises interrupt, pending
// - Any link event sets link summary bit
// - Link bit needs own and summary enable
// - Write one clears status bit, zero keeps
// - Pending summary readable in enable and status
// - Link pending summary reads zero once cleared
// - Link clears leave link summary bit set
// - Force request sets forced flag status bit
package plii_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int PLII_DATA_W = 32;
   localparam int PLII_ADDR_W = 8;
   localparam int PLII_PCI_SRC_W = 8;
   localparam int PLII_LINK_SRC_W = 16;
   localparam int PLII_PCI_STICKY_W = PLII_PCI_SRC_W + 2;
   localparam int PLII_COUNT_W = 16;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [PLII_ADDR_W-1:0] PLII_OFF_PCI_STATUS = 8'h00;
   localparam logic [PLII_ADDR_W-1:0] PLII_OFF_PCI_ENABLE = 8'h04;
   localparam logic [PLII_ADDR_W-1:0] PLII_OFF_LINK_STATUS = 8'h08;
   localparam logic [PLII_ADDR_W-1:0] PLII_OFF_LINK_ENABLE = 8'h0C;
   localparam logic [PLII_ADDR_W-1:0] PLII_OFF_MISC_CTRL = 8'h10;
   localparam logic [PLII_ADDR_W-1:0] PLII_OFF_IRQ_COUNT = 8'h14;

   // ----------------------------------------------------------------
   // Field positions in the register words
   // ----------------------------------------------------------------
   localparam int PLII_BIT_PENDING = 31;
   localparam int PLII_BIT_LINK_SUM = 30;
   localparam int PLII_BIT_FORCED = 29;
   localparam int PLII_BIT_LINK_PEND = 31;
   localparam int PLII_BIT_FORCE_REQ = 0;
   localparam int PLII_BIT_IRQ_LINE = 1;
   localparam int PLII_BIT_RX_DATA = 0;

   // Positions inside the bus-side sticky vector
   localparam int PLII_IDX_FORCED = PLII_PCI_SRC_W;
   localparam int PLII_IDX_LINK_SUM = PLII_PCI_SRC_W + 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [PLII_DATA_W-1:0] PLII_RST_WORD = 32'h0000_0000;
   localparam logic [PLII_PCI_SRC_W-1:0] PLII_RST_PCI_EN = 8'h00;
   localparam logic [PLII_LINK_SRC_W-1:0] PLII_RST_LINK_EN = 16'h0000;
   localparam logic [PLII_COUNT_W-1:0] PLII_RST_COUNT = 16'h0000;
   localparam logic [PLII_COUNT_W-1:0] PLII_COUNT_STEP = 16'h0001;

endpackage : plii_pkg

// File: core/plii_sticky_bits.sv
// Sticky status bits with write-one-to-clear, set beats clear
`timescale 1ns/10ps
module plii_sticky_bits
   import plii_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [W-1:0] set_in,
   input wire logic [W-1:0] clear_in,
   output logic [W-1:0] bits
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [W-1:0] next_bits;

   // Clear selected bits, then let new events win
   always_comb begin
      next_bits = (bits & ~clear_in) | set_in;
   end

   // Bits hold until cleared
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bits <= '0;
      end else begin
         bits <= next_bits;
      end
   end

endmodule : plii_sticky_bits

// File: core/plii_irq_ctrl.sv
// Interrupt aggregation: bus-side and link-side status, enables, line
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
module plii_irq_ctrl
   import plii_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [PLII_ADDR_W-1:0] addr,
   input wire logic [PLII_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [PLII_DATA_W-1:0] rdata,
   input wire logic [PLII_PCI_SRC_W-1:0] pci_event,
   input wire logic [PLII_LINK_SRC_W-1:0] link_event,
   output logic pci_int_n
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Any bit set in both words
   function automatic logic plii_any_and(
      input logic [PLII_DATA_W-1:0] a,
      input logic [PLII_DATA_W-1:0] b
   );
      plii_any_and = |(a & b);
   endfunction : plii_any_and

   // Address match qualified by a strobe
   function automatic logic plii_hit(
      input logic strobe,
      input logic [PLII_ADDR_W-1:0] a,
      input logic [PLII_ADDR_W-1:0] off
   );
      plii_hit = strobe && (a == off);
   endfunction : plii_hit

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic wr_pci_status;
   logic wr_pci_enable;
   logic wr_link_status;
   logic wr_link_enable;
   logic wr_misc;
   logic wr_count;

   logic [PLII_PCI_STICKY_W-1:0] pci_set;
   logic [PLII_PCI_STICKY_W-1:0] pci_clear;
   logic [PLII_PCI_STICKY_W-1:0] pci_bits;
   logic [PLII_LINK_SRC_W-1:0] link_clear;
   logic [PLII_LINK_SRC_W-1:0] link_bits;

   logic [PLII_PCI_SRC_W-1:0] pci_src_en;
   logic forced_en;
   logic link_sum_en;
   logic [PLII_LINK_SRC_W-1:0] link_en;

   logic force_req;
   logic link_sum_set;
   logic link_enabled_event;
   logic link_armed;
   logic next_link_armed;
   logic link_sum_cleared;

   logic link_pending_summary;
   logic pending_summary;
   logic pending_prev;
   logic [PLII_COUNT_W-1:0] irq_count;

   logic [PLII_DATA_W-1:0] pci_src_word;
   logic [PLII_DATA_W-1:0] pci_en_word;
   logic [PLII_DATA_W-1:0] link_bits_word;
   logic [PLII_DATA_W-1:0] link_en_word;
   logic [PLII_DATA_W-1:0] status_word;
   logic [PLII_DATA_W-1:0] enable_word;
   logic [PLII_DATA_W-1:0] link_status_word;
   logic [PLII_DATA_W-1:0] link_enable_word;
   logic [PLII_DATA_W-1:0] misc_word;
   logic [PLII_DATA_W-1:0] count_word;
   logic [PLII_DATA_W-1:0] next_rdata;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------

   // One strobe per register
   assign wr_pci_status = plii_hit(wr, addr, PLII_OFF_PCI_STATUS);
   assign wr_pci_enable = plii_hit(wr, addr, PLII_OFF_PCI_ENABLE);
   assign wr_link_status = plii_hit(wr, addr, PLII_OFF_LINK_STATUS);
   assign wr_link_enable = plii_hit(wr, addr, PLII_OFF_LINK_ENABLE);
   assign wr_misc = plii_hit(wr, addr, PLII_OFF_MISC_CTRL);
   assign wr_count = plii_hit(wr, addr, PLII_OFF_IRQ_COUNT);

   // ----------------------------------------------------------------
   // Event sources
   // ----------------------------------------------------------------

   // Force request is a self-clearing write pulse
   assign force_req = wr_misc && wdata[PLII_BIT_FORCE_REQ];

   // Any link event, enabled or not, marks the summary
   assign link_sum_set = |link_event;

   // Link event that software has chosen to hear
   assign link_enabled_event = |(link_event & link_en);

   // Bus-side set vector: sources, forced flag, link summary
   assign pci_set = {link_sum_set, force_req, pci_event};

   // Write-one clears; link summary only through this register
   assign pci_clear = wr_pci_status ?
      {wdata[PLII_BIT_LINK_SUM], wdata[PLII_BIT_FORCED],
       wdata[PLII_PCI_SRC_W-1:0]} :
      {PLII_PCI_STICKY_W{1'b0}};

   // Link-side clears touch only link bits
   assign link_clear = wr_link_status ?
      wdata[PLII_LINK_SRC_W-1:0] : {PLII_LINK_SRC_W{1'b0}};

   // ----------------------------------------------------------------
   // Status storage
   // ----------------------------------------------------------------

   // Bus-side sticky bits
   plii_sticky_bits #(
      .W(PLII_PCI_STICKY_W)
   ) u_pci_bits (
      .clock(clock),
      .rst(rst),
      .set_in(pci_set),
      .clear_in(pci_clear),
      .bits(pci_bits)
   );

   // Link-side sticky bits
   plii_sticky_bits #(
      .W(PLII_LINK_SRC_W)
   ) u_link_bits (
      .clock(clock),
      .rst(rst),
      .set_in(link_event),
      .clear_in(link_clear),
      .bits(link_bits)
   );

   // ----------------------------------------------------------------
   // Enable registers
   // ----------------------------------------------------------------

   // Bus-side enables, including forced and link summary enables
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pci_src_en <= PLII_RST_PCI_EN;
         forced_en <= 1'b0;
         link_sum_en <= 1'b0;
      end else if (wr_pci_enable) begin
         pci_src_en <= wdata[PLII_PCI_SRC_W-1:0];
         forced_en <= wdata[PLII_BIT_FORCED];
         link_sum_en <= wdata[PLII_BIT_LINK_SUM];
      end
   end

   // Link-side enables
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         link_en <= PLII_RST_LINK_EN;
      end else if (wr_link_enable) begin
         link_en <= wdata[PLII_LINK_SRC_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Link interrupt arming
   // ----------------------------------------------------------------

   // Summary cleared by software in this cycle
   assign link_sum_cleared = pci_clear[PLII_IDX_LINK_SUM];

   // Armed by an enabled link event, dropped with the summary
   always_comb begin
      next_link_armed = link_armed;
      if (link_sum_cleared) begin
         next_link_armed = 1'b0;
      end
      if (link_enabled_event) begin
         next_link_armed = 1'b1;
      end
   end

   // Arming flag storage
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         link_armed <= 1'b0;
      end else begin
         link_armed <= next_link_armed;
      end
   end

   // ----------------------------------------------------------------
   // Summaries
   // ----------------------------------------------------------------

   // Widened views for the helper function
   assign pci_src_word = {{(PLII_DATA_W-PLII_PCI_SRC_W){1'b0}},
                          pci_bits[PLII_PCI_SRC_W-1:0]};
   assign pci_en_word = {{(PLII_DATA_W-PLII_PCI_SRC_W){1'b0}}, pci_src_en};
   assign link_bits_word = {{(PLII_DATA_W-PLII_LINK_SRC_W){1'b0}}, link_bits};
   assign link_en_word = {{(PLII_DATA_W-PLII_LINK_SRC_W){1'b0}}, link_en};

   // Enabled link bit still standing
   assign link_pending_summary = plii_any_and(link_bits_word, link_en_word);

   // Any enabled bus-side source, forced flag or armed link summary
   assign pending_summary = plii_any_and(pci_src_word, pci_en_word)
      | (pci_bits[PLII_IDX_FORCED] & forced_en)
      | (pci_bits[PLII_IDX_LINK_SUM] & link_sum_en & link_armed);

   // ----------------------------------------------------------------
   // Interrupt line
   // ----------------------------------------------------------------

   // Level output, low while an enabled source stands
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pci_int_n <= 1'b1;
      end else begin
         pci_int_n <= ~pending_summary;
      end
   end

   // Count new assertions of the line for diagnostics
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pending_prev <= 1'b0;
         irq_count <= PLII_RST_COUNT;
      end else begin
         pending_prev <= pending_summary;
         if (wr_count) begin
            irq_count <= PLII_RST_COUNT;
         end else if (pending_summary && !pending_prev) begin
            irq_count <= irq_count + PLII_COUNT_STEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read words
   // ----------------------------------------------------------------

   // Bus-side status with pending summary on top
   always_comb begin
      status_word = PLII_RST_WORD;
      status_word[PLII_PCI_SRC_W-1:0] = pci_bits[PLII_PCI_SRC_W-1:0];
      status_word[PLII_BIT_FORCED] = pci_bits[PLII_IDX_FORCED];
      status_word[PLII_BIT_LINK_SUM] = pci_bits[PLII_IDX_LINK_SUM];
      status_word[PLII_BIT_PENDING] = pending_summary;
   end

   // Bus-side enables, same pending summary position
   always_comb begin
      enable_word = PLII_RST_WORD;
      enable_word[PLII_PCI_SRC_W-1:0] = pci_src_en;
      enable_word[PLII_BIT_FORCED] = forced_en;
      enable_word[PLII_BIT_LINK_SUM] = link_sum_en;
      enable_word[PLII_BIT_PENDING] = pending_summary;
   end

   // Link-side status with its pending summary
   always_comb begin
      link_status_word = link_bits_word;
      link_status_word[PLII_BIT_LINK_PEND] = link_pending_summary;
   end

   // Link enables as stored
   assign link_enable_word = link_en_word;

   // Force bit reads zero; line state shown beside it
   always_comb begin
      misc_word = PLII_RST_WORD;
      misc_word[PLII_BIT_IRQ_LINE] = ~pci_int_n;
   end

   // Assertion counter word
   assign count_word = {{(PLII_DATA_W-PLII_COUNT_W){1'b0}}, irq_count};

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------

   // Select word; unmapped offsets read zero
   always_comb begin
      next_rdata = PLII_RST_WORD;
      if (rd) begin
         unique case (addr)
            PLII_OFF_PCI_STATUS: next_rdata = status_word;
            PLII_OFF_PCI_ENABLE: next_rdata = enable_word;
            PLII_OFF_LINK_STATUS: next_rdata = link_status_word;
            PLII_OFF_LINK_ENABLE: next_rdata = link_enable_word;
            PLII_OFF_MISC_CTRL: next_rdata = misc_word;
            PLII_OFF_IRQ_COUNT: next_rdata = count_word;
            default: next_rdata = PLII_RST_WORD;
         endcase
      end
   end

   // Read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= PLII_RST_WORD;
      end else begin
         rdata <= next_rdata;
      end
   end

endmodule : plii_irq_ctrl

// File: testbench/plii_irq_ctrl_properties.sv
// Concurrent checks on the interrupt aggregation block ports
`timescale 1ns/10ps
module plii_irq_ctrl_props
   import plii_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [PLII_ADDR_W-1:0] addr,
   input wire logic [PLII_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [PLII_DATA_W-1:0] rdata,
   input wire logic [PLII_PCI_SRC_W-1:0] pci_event,
   input wire logic [PLII_LINK_SRC_W-1:0] link_event,
   input wire logic pci_int_n
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // Decoded accesses
   logic rd_st;
   logic rd_en;
   logic rd_ls;
   logic wr_st;
   logic wr_ls;
   logic wr_force;
   logic [15:0] wlo;
   assign rd_st = rd && (addr == PLII_OFF_PCI_STATUS);
   assign rd_en = rd && (addr == PLII_OFF_PCI_ENABLE);
   assign rd_ls = rd && (addr == PLII_OFF_LINK_STATUS);
   assign wr_st = wr && (addr == PLII_OFF_PCI_STATUS);
   assign wr_ls = wr && (addr == PLII_OFF_LINK_STATUS);
   assign wr_force = wr && (addr == PLII_OFF_MISC_CTRL) && wdata[PLII_BIT_FORCE_REQ];
   assign wlo = wdata[15:0];

   // Multi-step accesses
   sequence s_clear_read;
      wr_st ##1 rd_st;
   endsequence
   sequence s_link_clear_read;
      wr_ls ##1 rd_ls;
   endsequence
   sequence s_force_read;
      wr_force ##1 !wr ##1 rd_st;
   endsequence

   chk_read_quiet: assert property (!rd |=> rdata == 32'h0000_0000)
      else $error("read data not zero outside a read");
   chk_pend_line: assert property (rd_st |=> rdata[PLII_BIT_PENDING] == !pci_int_n)
      else $error("status pending bit disagrees with line");
   chk_pend_mirror: assert property (rd_en |=> rdata[PLII_BIT_PENDING] == !pci_int_n)
      else $error("enable pending bit disagrees with line");
   chk_sticky_set: assert property (rd_st |=>
      (rdata[7:0] & $past(pci_event, 2)) == $past(pci_event, 2))
      else $error("bus-side event bit not held");
   chk_summary_set: assert property (rd_st |=>
      rdata[PLII_BIT_LINK_SUM] || ($past(link_event, 2) == 16'h0000))
      else $error("link summary not set by link event");
   chk_link_set: assert property (rd_ls |=>
      (rdata[15:0] & $past(link_event, 2)) == $past(link_event, 2))
      else $error("link event bit not held");
   chk_status_clear: assert property (s_clear_read |=>
      (rdata[15:0] & $past(wlo, 2) & ~{8'h00, $past(pci_event, 2)} & 16'h00FF) == 16'h0000)
      else $error("status bit survived write of one");
   chk_link_clear: assert property (s_link_clear_read |=>
      (rdata[15:0] & $past(wlo, 2) & ~$past(link_event, 2)) == 16'h0000)
      else $error("link bit survived write of one");
   chk_force_flag: assert property (s_force_read |=> rdata[PLII_BIT_FORCED])
      else $error("forced flag not set by request");
endmodule : plii_irq_ctrl_props

bind plii_irq_ctrl plii_irq_ctrl_props plii_irq_ctrl_props_i (.clock(clock), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pci_event(pci_event),
   .link_event(link_event), .pci_int_n(pci_int_n));

// File: testbench/plii_event_src.sv
// Model of the hardware event sources feeding the block
`timescale 1ns/10ps
module plii_event_src
   import plii_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic go,
   input wire logic [PLII_PCI_SRC_W-1:0] pci_req,
   input wire logic [PLII_LINK_SRC_W-1:0] link_req,
   output logic [PLII_PCI_SRC_W-1:0] pci_event,
   output logic [PLII_LINK_SRC_W-1:0] link_event
);
   // One-cycle event pulse per request, quiet between
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pci_event <= 8'h00;
         link_event <= 16'h0000;
      end else begin
         pci_event <= go ? pci_req : 8'h00;
         link_event <= go ? link_req : 16'h0000;
      end
   end
endmodule : plii_event_src

// File: testbench/plii_irq_ctrl_test.sv
// Self-checking bench for the interrupt aggregation block
`timescale 1ns/10ps
module plii_irq_ctrl_test import plii_pkg::*;;
   logic clock;
   logic rst;
   logic [PLII_ADDR_W-1:0] addr;
   logic [PLII_DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [PLII_DATA_W-1:0] rdata;
   logic [PLII_PCI_SRC_W-1:0] pci_event;
   logic [PLII_LINK_SRC_W-1:0] link_event;
   logic pci_int_n;
   logic go;
   logic [PLII_PCI_SRC_W-1:0] pci_req;
   logic [PLII_LINK_SRC_W-1:0] link_req;
   int n_mismatch;
   int n_compared;

   plii_irq_ctrl plii_irq_ctrl_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pci_event(pci_event), .link_event(link_event),
      .pci_int_n(pci_int_n));
   plii_event_src plii_event_src_i (.clock(clock), .rst(rst), .go(go), .pci_req(pci_req),
      .link_req(link_req), .pci_event(pci_event), .link_event(link_event));

   // Free-running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ------------------------------------------------------------
   // Access and check tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      cmp($sformatf("rdata at %h", a), exp, rdata);
   endtask : rd_chk

   // Write then read back at the same place with no idle cycle between
   task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      cmp($sformatf("rdata at %h", a), exp, rdata);
   endtask : wr_rd_chk

   task automatic fire(input logic [7:0] p, input logic [15:0] l);
      @(posedge clock);
      go <= 1'b1;
      pci_req <= p;
      link_req <= l;
      @(posedge clock);
      go <= 1'b0;
   endtask : fire

   task automatic chk_line(input logic exp);
      int i;
      i = 0;
      @(negedge clock);
      while (pci_int_n !== exp && i < 8) begin
         @(negedge clock);
         i++;
      end
      cmp("pci_int_n", {31'h0000_0000, exp}, {31'h0000_0000, pci_int_n});
      if (pci_int_n !== exp) begin
         report_and_stop();
      end
   endtask : chk_line

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
      go = 1'b0;
      pci_req = 8'h00;
      link_req = 16'h0000;
      n_mismatch = 0;
      n_compared = 0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      // Reset values, one unmapped place at the end
      chk_line(1'b1);
      for (int k = 0; k < 7; k++) begin
         rd_chk(8'(4 * k), 32'h0000_0000);
      end
      // Enabled bus-side source
      wr_reg(PLII_OFF_PCI_ENABLE, 32'h0000_0001);
      fire(8'h01, 16'h0000);
      rd_chk(PLII_OFF_PCI_STATUS, 32'h8000_0001);
      rd_chk(PLII_OFF_PCI_ENABLE, 32'h8000_0001);
      chk_line(1'b0);
      rd_chk(PLII_OFF_IRQ_COUNT, 32'h0000_0001);
      wr_reg(PLII_OFF_IRQ_COUNT, 32'h0000_0000);
      rd_chk(PLII_OFF_IRQ_COUNT, 32'h0000_0000);
      // Unenabled sources, partial multi-bit clear
      fire(8'h06, 16'h0000);
      rd_chk(PLII_OFF_PCI_STATUS, 32'h8000_0007);
      wr_rd_chk(PLII_OFF_PCI_STATUS, 32'h0000_0005, 32'h0000_0002);
      chk_line(1'b1);
      wr_reg(PLII_OFF_PCI_STATUS, 32'h0000_0002);
      rd_chk(PLII_OFF_PCI_STATUS, 32'h0000_0000);
      // Enabled link source, summary enable off then on
      wr_reg(PLII_OFF_LINK_ENABLE, 32'h0000_0008);
      fire(8'h00, 16'h0008);
      rd_chk(PLII_OFF_PCI_STATUS, 32'h4000_0000);
      chk_line(1'b1);
      wr_reg(PLII_OFF_PCI_ENABLE, 32'h4000_0001);
      chk_line(1'b0);
      rd_chk(PLII_OFF_LINK_STATUS, 32'h8000_0008);
      wr_rd_chk(PLII_OFF_LINK_STATUS, 32'h0000_0008, 32'h0000_0000);
      rd_chk(PLII_OFF_PCI_STATUS, 32'hC000_0000);
      wr_reg(PLII_OFF_PCI_STATUS, 32'h4000_0000);
      rd_chk(PLII_OFF_PCI_STATUS, 32'h0000_0000);
      chk_line(1'b1);
      // Frequent receive source left unenabled and polled
      fire(8'h00, 16'h0001);
      rd_chk(PLII_OFF_LINK_STATUS, 32'h0000_0001);
      chk_line(1'b1);
      wr_reg(PLII_OFF_LINK_STATUS, 32'h0000_0001);
      rd_chk(PLII_OFF_LINK_STATUS, 32'h0000_0000);
      wr_reg(PLII_OFF_PCI_STATUS, 32'h4000_0000);
      // Forced test interrupt
      wr_reg(PLII_OFF_MISC_CTRL, 32'h0000_0001);
      rd_chk(PLII_OFF_PCI_STATUS, 32'h2000_0000);
      wr_reg(PLII_OFF_PCI_ENABLE, 32'h2000_0000);
      chk_line(1'b0);
      rd_chk(PLII_OFF_MISC_CTRL, 32'h0000_0002);
      wr_reg(PLII_OFF_PCI_STATUS, 32'h2000_0000);
      chk_line(1'b1);
      report_and_stop();
   end
endmodule : plii_irq_ctrl_test
